// ===== tb_top.sv
// Self-checking bench for the translation buffer test access logic
`timescale 1ns/10ps
module tb_top;
  import tta_pkg::*;
  // ==========================================
  // Stimulus and observed signals
  logic clock;
  logic arst_n;
  tta_treg_req_t treg_req;
  logic treg_rd_sel;
  logic [31:0] treg_rdata;
  logic fill_en;
  logic [19:0] fill_lin;
  tta_data_t fill_data;
  logic [3:0] fill_prot;
  logic fill_ready;
  int err_count;
  int compares;
  int cycles;
  logic [31:0] rd;
  // Addresses: set 1 twice, set 5, set 6
  localparam logic [19:0] LIN_A = 20'h0_0011;
  localparam logic [19:0] LIN_B = 20'h0_0021;
  localparam logic [19:0] LIN_E = 20'hA_BCD5;
  localparam logic [19:0] LIN_F = 20'h0_0036;
  // Protection for stored zeros: V plus 01 pairs
  localparam logic [6:0] PROT_Z = 7'b1_01_01_01;

  // Device under test
  tta_tlb_test tta_tlb_test_i (
    .clock(clock),
    .arst_n(arst_n),
    .treg_req(treg_req),
    .treg_rd_sel(treg_rd_sel),
    .treg_rdata(treg_rdata),
    .fill_en(fill_en),
    .fill_lin(fill_lin),
    .fill_data(fill_data),
    .fill_prot(fill_prot),
    .fill_ready(fill_ready)
  );

  // ==========================================
  // Clock, 5 ns period
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Hang guard, far above the roughly sixty cycles needed
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      err_count = err_count + 1;
      wrap_up();
    end
  end

  // ==========================================
  // Helpers
  // Compare a register word under a mask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
    compares = compares + 1;
    if ((got & msk) !== (exp & msk)) begin
      err_count = err_count + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got & msk, exp & msk);
    end
  endtask
  // One-cycle write strobe to a test register
  task automatic wreg(input logic sel, input logic [31:0] d);
    @(negedge clock);
    treg_req = '{wr: 1'b1, sel: sel, wdata: d};
    @(negedge clock);
    treg_req.wr = 1'b0;
  endtask
  // Read a test register through the mux
  task automatic rreg(input logic sel, output logic [31:0] q);
    treg_rd_sel = sel;
    #1 q = treg_rdata;
  endtask
  // Command word: address, seven protection bits, op
  function automatic logic [31:0] cw(input logic [19:0] lin, input logic [6:0] p, input logic op);
    return {lin, p, 4'h0, op};
  endfunction
  // Data word: page, attributes, tree, pointer flag, way
  function automatic logic [31:0] dw(input logic [19:0] pa, input logic [1:0] at,
                                     input logic [2:0] lru, input logic pf, input logic [1:0] way);
    return {pa, at, lru, 2'b00, pf, way, 2'b00};
  endfunction
  // Lookup then fetch the data register
  task automatic look(input logic [19:0] lin, input logic [6:0] p, output logic [31:0] q);
    wreg(1'b0, cw(lin, p, 1'b1));
    rreg(1'b1, q);
  endtask
  // Verdict and end of run
  task automatic wrap_up();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================
  // Scenarios
  // Reset value of the command register and reserved bits of both registers
  task automatic t_regs();
    rreg(1'b0, rd);
    chk(rd, 32'h0000_0000, 32'hFFFF_FFFF);
    wreg(1'b1, 32'hFFFF_FFFF);
    rreg(1'b1, rd);
    chk(rd, 32'hFFFF_FF9C, 32'hFFFF_FFFF);
    wreg(1'b0, 32'hFFFF_FFFF);
    rreg(1'b0, rd);
    chk(rd, 32'hFFFF_FFE1, 32'hFFFF_FFFF);
    rreg(1'b1, rd);
    chk(rd, 32'h0000_0000, 32'h0000_0010);
    $display("test regs done");
  endtask
  // Explicit way write, garbage tree field, then hit
  task automatic t_explicit();
    wreg(1'b1, dw(20'h1_2345, 2'b10, 3'b111, 1'b1, 2'b10));
    wreg(1'b0, cw(LIN_E, 7'b1_10_01_10, 1'b0));
    look(LIN_E, 7'b1_10_01_10, rd);
    chk(rd, dw(20'h1_2345, 2'b10, 3'b100, 1'b1, 2'b10), 32'hFFFF_FF9C);
    rreg(1'b0, rd);
    chk(rd, cw(LIN_E, 7'b1_10_01_10, 1'b1), 32'hFFFF_FFFF);
    $display("test explicit done");
  endtask
  // All four lookup pairs on stored dirty 1, and valid off
  task automatic t_pairs();
    for (int i = 0; i < 4; i++) begin
      look(LIN_E, {1'b1, i[1:0], 4'b0110}, rd);
      chk(rd, {27'h0, i[1], 4'h0}, 32'h0000_0010);
    end
    look(LIN_E, 7'b0_10_01_10, rd);
    chk(rd, 32'h0000_0000, 32'h0000_0010);
    $display("test pairs done");
  endtask
  // Tree-chosen victims and tree updates in set 1
  task automatic t_lru();
    wreg(1'b1, dw(20'h0_AAAA, 2'b00, 3'b111, 1'b0, 2'b11));
    wreg(1'b0, cw(LIN_A, PROT_Z, 1'b0));
    look(LIN_A, PROT_Z, rd);
    chk(rd, dw(20'h0_AAAA, 2'b00, 3'b011, 1'b1, 2'b00), 32'hFFFF_FF9C);
    wreg(1'b1, dw(20'h0_BBBB, 2'b01, 3'b000, 1'b0, 2'b00));
    wreg(1'b0, cw(LIN_B, PROT_Z, 1'b0));
    look(LIN_B, PROT_Z, rd);
    chk(rd, dw(20'h0_BBBB, 2'b01, 3'b110, 1'b1, 2'b10), 32'hFFFF_FF9C);
    look(LIN_A, PROT_Z, rd);
    chk(rd, dw(20'h0_AAAA, 2'b00, 3'b110, 1'b1, 2'b00), 32'hFFFF_FF9C);
    look(LIN_A, PROT_Z, rd);
    chk(rd, dw(20'h0_AAAA, 2'b00, 3'b111, 1'b1, 2'b00), 32'hFFFF_FF9C);
    $display("test lru done");
  endtask
  // Same address twice in one set never hits
  task automatic t_dup();
    wreg(1'b1, dw(20'h0_CCCC, 2'b00, 3'b000, 1'b1, 2'b11));
    wreg(1'b0, cw(LIN_A, PROT_Z, 1'b0));
    look(LIN_A, PROT_Z, rd);
    chk(rd, 32'h0000_0000, 32'h0000_0010);
    $display("test dup done");
  endtask
  // Fill refused under a command write, then accepted
  task automatic t_fill();
    @(negedge clock);
    treg_req = '{wr: 1'b1, sel: 1'b0, wdata: cw(20'h0_0007, PROT_Z, 1'b1)};
    fill_en = 1'b1;
    fill_lin = LIN_F;
    fill_data = '{phys: 20'h5_5555, page_cache_disable_attr: 1'b1, page_write_through_attr: 1'b0};
    fill_prot = 4'b1000;
    #1 chk({31'h0, fill_ready}, 32'h0000_0000, 32'h0000_0001);
    @(negedge clock);
    treg_req.wr = 1'b0;
    fill_en = 1'b0;
    look(LIN_F, PROT_Z, rd);
    chk(rd, 32'h0000_0000, 32'h0000_0010);
    @(negedge clock);
    fill_en = 1'b1;
    #1 chk({31'h0, fill_ready}, 32'h0000_0001, 32'h0000_0001);
    @(negedge clock);
    fill_en = 1'b0;
    look(LIN_F, PROT_Z, rd);
    chk(rd, dw(20'h5_5555, 2'b10, 3'b011, 1'b1, 2'b00), 32'hFFFF_FF9C);
    $display("test fill done");
  endtask

  // ==========================================
  // Main sequence
  initial begin
    err_count = 0;
    compares = 0;
    cycles = 0;
    arst_n = 1'b0;
    treg_req = '0;
    treg_rd_sel = 1'b0;
    fill_en = 1'b0;
    fill_lin = 20'h0_0000;
    fill_data = '0;
    fill_prot = 4'h0;
    repeat (8) @(posedge clock);
    @(negedge clock);
    arst_n = 1'b1;
    t_regs();
    t_explicit();
    t_pairs();
    t_lru();
    t_dup();
    t_fill();
    wrap_up();
  end
endmodule

// ===== tta_map.svh
// Offsets, field positions and reset values for the translation buffer test access
`ifndef TTA_MAP_SVH
`define TTA_MAP_SVH
// ==========================================
// Register select on the test register port
`define TTA_SEL_CMD 1'b0
`define TTA_SEL_DATA 1'b1
// ==========================================
// Command register fields
`define TTA_CMD_OP 0
`define TTA_CMD_WN 5
`define TTA_CMD_W 6
`define TTA_CMD_UN 7
`define TTA_CMD_U 8
`define TTA_CMD_DN 9
`define TTA_CMD_D 10
`define TTA_CMD_V 11
`define TTA_CMD_SET_LO 12
`define TTA_CMD_SET_HI 14
`define TTA_CMD_TAG_LO 15
`define TTA_CMD_MASK 32'hFFFF_FFE1
// ==========================================
// Data register fields
`define TTA_DAT_WAY_LO 2
`define TTA_DAT_WAY_HI 3
`define TTA_DAT_PTR 4
`define TTA_DAT_LRU_LO 7
`define TTA_DAT_LRU_HI 9
`define TTA_DAT_PWT 10
`define TTA_DAT_PCD 11
`define TTA_DAT_PA_LO 12
`define TTA_DAT_MASK 32'hFFFF_FF9C
// ==========================================
// Reset values
`define TTA_CMD_RST 32'h0000_0000
`define TTA_DAT_RST 32'h0000_0000
`define TTA_LRU_RST 3'h0
`endif

// ===== tta_pkg.sv
// Types shared by the translation buffer test access logic
package tta_pkg;
  // Stored tag entry, 21 bits
  typedef struct packed {
    logic valid;
    logic dirty;
    logic user;
    logic rw;
    logic [16:0] tag;
  } tta_tag_t;
  // Stored data entry, 22 bits
  typedef struct packed {
    logic [19:0] phys;
    logic page_cache_disable_attr;
    logic page_write_through_attr;
  } tta_data_t;
  // Test register write request
  typedef struct packed {
    logic wr;
    logic sel;
    logic [31:0] wdata;
  } tta_treg_req_t;
endpackage

// ===== tta_tlb_test.sv
// Translation buffer with its command and data test registers
`timescale 1ns/10ps
`include "tta_map.svh"

// Operation
// - Four ways by eight sets, separate arrays
// - Data entry: 20-bit page plus two attributes
// - Tag entry: 17-bit tag plus four protection
// - Three-bit pseudo-LRU state per set
// - Command register write triggers the operation
// - Command: address 31:12, protection 11:5, op 0
// - Low three address bits select set
// - Op bit 0 writes, 1 looks up
// - Valid single; dirty, user, rw paired
// - Write pair 01 stores 0, 10 stores 1
// - Lookup pairs: miss, match 0, 1, any
// - Data register field layout
// - Pointer bit picks LRU or given way
// - Lookup sets bit 4 on hit only
// - Hit loads page, attributes, LRU, way
// - Test write ignores data register LRU field
// - Every write makes entry most recently used
// - Lookup hits update the set LRU state
// - Duplicate address in set never hits
// - Works with paging enabled
// - Both registers readable and writable
// - After miss only bit 4 meaningful
// - Reported LRU is pre-update state
module tta_tlb_test #(
  parameter int WAYS = 4,
  parameter int SETS = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Test register port
  input wire tta_pkg::tta_treg_req_t treg_req,
  input wire logic treg_rd_sel,
  output logic [31:0] treg_rdata,
  // Normal fill port
  input wire logic fill_en,
  input wire logic [19:0] fill_lin,
  input wire tta_pkg::tta_data_t fill_data,
  input wire logic [3:0] fill_prot,
  output logic fill_ready
);
  import tta_pkg::*;

  initial begin
    if (WAYS != 4 || SETS != 8) begin
      $error("tta_tlb_test serves only four ways by eight sets");
    end
  end

  // ==========================================
  // Helper functions

  // Bit 0 picks the half, bits 1 and 2 the way
  // Valid bits play no part in the choice
  // Pseudo-LRU victim from tree bits
  function automatic logic [1:0] plru_victim(input logic [2:0] lru);
    plru_victim = lru[0] ? {1'b1, lru[2]} : {1'b0, lru[1]};
  endfunction

  // Touched way becomes most recently used
  // Other half keeps its bit unchanged
  // Tree bits after touching a way
  function automatic logic [2:0] plru_touch(input logic [2:0] lru, input logic [1:0] way);
    logic [2:0] r;
    r = lru;
    r[0] = ~way[1];
    if (way[1]) begin
      r[2] = ~way[0];
    end else begin
      r[1] = ~way[0];
    end
    plru_touch = r;
  endfunction

  // Pair 00 never matches, 11 always
  // Pair 01 wants a stored 0, 10 a stored 1
  // Lookup match of one protection pair
  function automatic logic pair_match(input logic t, input logic c, input logic s);
    pair_match = (t & c) | (t & ~c & s) | (~t & c & ~s);
  endfunction

  // ==========================================
  // State

  // Arrays sized for four ways by eight sets
  // Tree bits reset to zero, victim way 0
  tta_tag_t tag_q [4][8];  // Tag arrays, one per way
  tta_data_t dat_q [4][8]; // Data arrays, one per way
  logic [2:0] lru_q [8];   // Tree bits per set
  logic [31:0] cmd_q;      // Command test register
  logic [31:0] data_q;     // Data test register

  // ==========================================
  // Request decode

  // Write word, shared by both registers
  wire [31:0] cw = treg_req.wdata;
  // Strobe split by register select
  wire cmd_wr = treg_req.wr & (treg_req.sel == `TTA_SEL_CMD);
  wire data_wr = treg_req.wr & (treg_req.sel == `TTA_SEL_DATA);
  // Operation bit picks write or lookup
  wire test_wr = cmd_wr & ~cw[`TTA_CMD_OP];
  wire test_lk = cmd_wr & cw[`TTA_CMD_OP];
  // Set index and stored tag from the address
  wire [2:0] cmd_set = cw[`TTA_CMD_SET_HI:`TTA_CMD_SET_LO];
  wire [16:0] cmd_tag = cw[31:`TTA_CMD_TAG_LO];
  // Tree bits of the addressed set
  wire [2:0] set_lru = lru_q[cmd_set];

  // ==========================================
  // Lookup compare, one per way

  // One match bit per way
  logic [3:0] way_match;
  genvar gw;
  generate
    for (gw = 0; gw < 4; gw++) begin : g_way
      // Stored tag of this way in the set
      tta_tag_t st;
      assign st = tag_q[gw][cmd_set];
      // Valid is single, others use pairs
      assign way_match[gw] = st.valid & cw[`TTA_CMD_V] & (st.tag == cmd_tag)
        & pair_match(cw[`TTA_CMD_D], cw[`TTA_CMD_DN], st.dirty)
        & pair_match(cw[`TTA_CMD_U], cw[`TTA_CMD_UN], st.user)
        & pair_match(cw[`TTA_CMD_W], cw[`TTA_CMD_WN], st.rw);
    end
  endgenerate

  // Exactly one matching way counts as a hit
  wire hit = (way_match != 4'h0) && ((way_match & (way_match - 4'h1)) == 4'h0);
  // Encode the single matching way
  wire [1:0] hit_way = {way_match[3] | way_match[2], way_match[3] | way_match[1]};
  // Two or more ways claim the address
  wire multi = (way_match & (way_match - 4'h1)) != 4'h0;

  // ==========================================
  // Write selection

  wire ptr_given = data_q[`TTA_DAT_PTR];
  // Way from pointer bits or from tree bits
  wire [1:0] test_way = ptr_given ? data_q[`TTA_DAT_WAY_HI:`TTA_DAT_WAY_LO]
                                  : plru_victim(set_lru);
  assign fill_ready = ~cmd_wr;  // Test operation owns the arrays
  // Fill taken only when no command write
  wire fill_fire = fill_en & fill_ready;
  // One array write per cycle at most
  wire upd_en = test_wr | fill_fire;
  // Test write wins over a fill
  wire [2:0] upd_set = test_wr ? cmd_set : fill_lin[2:0];
  wire [1:0] upd_way = test_wr ? test_way : plru_victim(lru_q[fill_lin[2:0]]);

  // New tag from pairs' true bits, data from the data register
  // Undefined pairs store their true bit
  tta_tag_t test_tag;
  assign test_tag = '{valid: cw[`TTA_CMD_V], dirty: cw[`TTA_CMD_D],
                      user: cw[`TTA_CMD_U], rw: cw[`TTA_CMD_W], tag: cmd_tag};
  // Fill protection is valid, dirty, user, rw
  tta_tag_t fill_tag;
  assign fill_tag = '{valid: fill_prot[3], dirty: fill_prot[2], user: fill_prot[1],
                      rw: fill_prot[0], tag: fill_lin[19:3]};
  tta_data_t test_dat;
  // Data register LRU field plays no part here
  assign test_dat = '{phys: data_q[31:`TTA_DAT_PA_LO],
                      page_cache_disable_attr: data_q[`TTA_DAT_PCD],
                      page_write_through_attr: data_q[`TTA_DAT_PWT]};
  // Selected entry for the array write
  tta_tag_t upd_tag;
  assign upd_tag = test_wr ? test_tag : fill_tag;
  tta_data_t upd_dat;
  assign upd_dat = test_wr ? test_dat : fill_data;

  // Lookup result word
  // Entry of the hit way, same set
  tta_data_t hit_dat;
  assign hit_dat = dat_q[hit_way][cmd_set];
  wire [31:0] hit_word = {hit_dat.phys, hit_dat.page_cache_disable_attr,
                          hit_dat.page_write_through_attr, set_lru, 2'b00, 1'b1,
                          hit_way, 2'b00};
  // Miss keeps old contents, clears the flag
  wire [31:0] miss_word = data_q & ~(32'h0000_0001 << `TTA_DAT_PTR);

  // ==========================================
  // Entry arrays; writes land in one cycle
  // Only the chosen way and set change

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tag_q <= '{default: '0};
      dat_q <= '{default: '0};
    end else if (upd_en) begin
      tag_q[upd_way][upd_set] <= upd_tag;
      dat_q[upd_way][upd_set] <= upd_dat;
    end
  end

  // ==========================================
  // Tree bits: writes and lookup hits touch them
  // A miss leaves the tree bits alone

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lru_q <= '{default: `TTA_LRU_RST};
    end else if (upd_en) begin
      lru_q[upd_set] <= plru_touch(lru_q[upd_set], upd_way);
    end else if (test_lk && hit) begin
      lru_q[cmd_set] <= plru_touch(set_lru, hit_way);
    end
  end

  // ==========================================
  // Test registers
  // Reserved bits are dropped on write

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cmd_q <= `TTA_CMD_RST;
    end else if (cmd_wr) begin
      cmd_q <= cw & `TTA_CMD_MASK;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      data_q <= `TTA_DAT_RST;
    end else if (data_wr) begin
      data_q <= cw & `TTA_DAT_MASK;
    end else if (test_lk) begin
      data_q <= hit ? hit_word : miss_word;
    end
  end

  // Read mux over the two registers
  assign treg_rdata = (treg_rd_sel == `TTA_SEL_DATA) ? data_q : cmd_q;

  // ==========================================
  // Checks

  wire d_forced_miss = cw[`TTA_CMD_D] == 1'b0 && cw[`TTA_CMD_DN] == 1'b0;
  wire [1:0] victim_now = plru_victim(set_lru);

  lookup_hit_flag_a: assert property (@(posedge clock) disable iff (!arst_n)
    test_lk |=> data_q[`TTA_DAT_PTR] == $past(hit))
    else $error("hit flag does not follow lookup result");

  hit_way_report_a: assert property (@(posedge clock) disable iff (!arst_n)
    (test_lk && hit) |=> data_q[`TTA_DAT_WAY_HI:`TTA_DAT_WAY_LO] == $past(hit_way))
    else $error("hit way not reported");

  lru_preupdate_a: assert property (@(posedge clock) disable iff (!arst_n)
    (test_lk && hit) |=> data_q[`TTA_DAT_LRU_HI:`TTA_DAT_LRU_LO] == $past(set_lru))
    else $error("reported tree bits are not the old ones");

  given_way_a: assert property (@(posedge clock) disable iff (!arst_n)
    (test_wr && ptr_given) |-> upd_way == data_q[`TTA_DAT_WAY_HI:`TTA_DAT_WAY_LO])
    else $error("given way not used on test write");

  write_mru_a: assert property (@(posedge clock) disable iff (!arst_n)
    test_wr ##1 (!cmd_wr && !fill_en) |-> $past(cw[`TTA_CMD_OP]) == 1'b0
      && plru_victim(lru_q[$past(cmd_set)]) != $past(upd_way))
    else $error("written entry is still the victim");

  lookup_mru_a: assert property (@(posedge clock) disable iff (!arst_n)
    (test_lk && hit) |=> plru_victim(lru_q[$past(cmd_set)]) != $past(hit_way))
    else $error("lookup hit left the way as victim");

  duplicate_miss_a: assert property (@(posedge clock) disable iff (!arst_n)
    (test_lk && multi) |=> !data_q[`TTA_DAT_PTR])
    else $error("duplicate entries reported a hit");

  forced_miss_a: assert property (@(posedge clock) disable iff (!arst_n)
    (test_lk && d_forced_miss) |-> !hit)
    else $error("forced miss pair produced a hit");

  write_store_a: assert property (@(posedge clock) disable iff (!arst_n)
    test_wr |=> dat_q[$past(upd_way)][$past(cmd_set)].phys == $past(data_q[31:12]))
    else $error("page address not stored on test write");

  lru_write_way_a: assert property (@(posedge clock) disable iff (!arst_n)
    (test_wr && !ptr_given) |-> upd_way == victim_now)
    else $error("tree victim not used on test write");

  // Command register takes the masked word
  cmd_store_a: assert property (@(posedge clock) disable iff (!arst_n)
    cmd_wr |=> cmd_q == ($past(cw) & `TTA_CMD_MASK))
    else $error("command register not loaded");

  // Data register takes the masked word
  data_store_a: assert property (@(posedge clock) disable iff (!arst_n)
    data_wr |=> data_q == ($past(cw) & `TTA_DAT_MASK))
    else $error("data register not loaded");

  // Write pairs store their true bits
  write_pair_a: assert property (@(posedge clock) disable iff (!arst_n)
    test_wr |=> tag_q[$past(upd_way)][$past(cmd_set)].dirty == $past(cw[`TTA_CMD_D])
      && tag_q[$past(upd_way)][$past(cmd_set)].user == $past(cw[`TTA_CMD_U])
      && tag_q[$past(upd_way)][$past(cmd_set)].rw == $past(cw[`TTA_CMD_W]))
    else $error("protection pair not stored");

  // Upper address bits land in the tag array
  tag_store_a: assert property (@(posedge clock) disable iff (!arst_n)
    test_wr |=> tag_q[$past(upd_way)][$past(cmd_set)].tag == $past(cmd_tag))
    else $error("tag not stored on test write");

  // Single valid bit is stored as given
  valid_store_a: assert property (@(posedge clock) disable iff (!arst_n)
    test_wr |=> tag_q[$past(upd_way)][$past(cmd_set)].valid == $past(cw[`TTA_CMD_V]))
    else $error("valid bit not stored");

  // Page attributes come from the data register
  attr_store_a: assert property (@(posedge clock) disable iff (!arst_n)
    test_wr |=> dat_q[$past(upd_way)][$past(cmd_set)].page_cache_disable_attr
      == $past(data_q[`TTA_DAT_PCD])
      && dat_q[$past(upd_way)][$past(cmd_set)].page_write_through_attr
      == $past(data_q[`TTA_DAT_PWT]))
    else $error("page attributes not stored");

  // Miss only clears the flag bit
  miss_keep_a: assert property (@(posedge clock) disable iff (!arst_n)
    (test_lk && !hit) |=> data_q[31:5] == $past(data_q[31:5])
      && data_q[3:0] == $past(data_q[3:0]))
    else $error("miss disturbed the data register");

  // Miss leaves the set tree bits alone
  miss_lru_a: assert property (@(posedge clock) disable iff (!arst_n)
    (test_lk && !hit) |=> lru_q[$past(cmd_set)] == $past(set_lru))
    else $error("lookup miss changed the tree bits");

  // Fill refused under a command write
  fill_block_a: assert property (@(posedge clock) disable iff (!arst_n)
    cmd_wr |-> !fill_ready)
    else $error("fill accepted during command write");

  // Hit reports the stored page address
  hit_page_a: assert property (@(posedge clock) disable iff (!arst_n)
    (test_lk && hit) |=> data_q[31:12] == $past(hit_dat.phys))
    else $error("hit page address not reported");

  // Command register holds between writes
  cmd_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
    !cmd_wr |=> $stable(cmd_q))
    else $error("command register changed unasked");

  // Data register holds between operations
  data_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
    (!data_wr && !test_lk) |=> $stable(data_q))
    else $error("data register changed unasked");

  // Filled entry becomes most recently used
  fill_mru_a: assert property (@(posedge clock) disable iff (!arst_n)
    fill_fire |=> plru_victim(lru_q[$past(upd_set)]) != $past(upd_way))
    else $error("filled entry is still the victim");
endmodule
